// [pft_pkg.sv]
// Purpose: Shared constants and types for the program flash table access
// Assumes: 100 MHz core clock, byte-wide register port toward the core
// Notes: Device register selects, host Avalon offsets and timing live here
package pft_pkg;
  // Clock and self-timed programming
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 2; // Plain default, real figure unknown
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // Memory geometry
  localparam int FLASH_BYTES = 4096;
  localparam int PTR_W = 12;
  localparam int WADDR_W = 11;
  localparam int EE_BYTES = 256;
  localparam int CFG_BYTES = 16;
  localparam int WR_BLK = 8;
  localparam int ER_BLK = 64;

  // Device register selects on the core port
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_UNLOCK = 3'h1;
  localparam logic [2:0] SEL_LATCH = 3'h2;
  localparam logic [2:0] SEL_EEPROM_DATA_REGISTER = 3'h3;
  localparam logic [2:0] SEL_EEPROM_ADDRESS_REGISTER = 3'h4;
  localparam logic [2:0] SEL_IRQF = 3'h5;

  // Fields of memory_access_control
  localparam int CTL_SPACE = 7;
  localparam int CTL_CFG = 6;
  localparam int CTL_ERASE = 4;
  localparam int CTL_ABORT = 3;
  localparam int CTL_GATE = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;
  localparam int IRQF_WC = 0;

  // Unlock sequence values and invalid opcode decode
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [15:0] INV_MASK = 16'hff00;
  localparam logic [15:0] INV_VAL = 16'h0100;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Host Avalon byte offsets
  localparam logic [5:0] AV_DEVREG = 6'h00; // 0x00..0x1c: device regs
  localparam logic [5:0] AV_PTR = 6'h20;
  localparam logic [5:0] AV_TBLOP = 6'h24;
  localparam logic [5:0] AV_STATUS = 6'h28;
  localparam logic [5:0] AV_FETCH = 6'h2c;

  typedef enum logic [1:0] {TGT_EE, TGT_CFG, TGT_FWR, TGT_FER} pft_tgt_t;
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} pft_unlock_t;
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ACK} pft_hst_t;
endpackage

// [pft_if.sv]
// Purpose: Link between the processor core end and the memory end
// Assumes: All signals synchronous to the one core clock
// Notes: Pulses last one cycle; read data is answered by rvalid
interface pft_if;
  import pft_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_sel;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic tbl_rd;
  logic tbl_wr;
  logic [PTR_W-1:0] tbl_ptr;
  logic [WADDR_W-1:0] fetch_addr;
  logic [15:0] fetch_word;
  logic fetch_stall;
  modport core (output reg_wr, reg_rd, reg_sel, reg_wdata, tbl_rd, tbl_wr,
    tbl_ptr, fetch_addr, input reg_rdata, reg_rvalid, fetch_word,
    fetch_stall);
  modport mem (input reg_wr, reg_rd, reg_sel, reg_wdata, tbl_rd, tbl_wr,
    tbl_ptr, fetch_addr, output reg_rdata, reg_rvalid, fetch_word,
    fetch_stall);
endinterface

// [pft_mem_end.sv]
// Purpose: Memory end: flash, data EEPROM, config space, table latch
// Assumes: Core stops issuing table ops while fetch_stall is high
// Notes: Arrays carry no reset so contents survive a device reset
module pft_mem_end
  import pft_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  pft_if.mem bus,
  output logic o_irq_flag,
  output logic o_abort_flag
);
  logic [7:0] flash_q [FLASH_BYTES];
  logic [7:0] ee_q [EE_BYTES];
  logic [7:0] cfgm_q [CFG_BYTES];
  logic [7:0] hold_q [WR_BLK];
  logic space_q, cfgsel_q, erase_q, abort_q, gate_q, wr_q, rd_q, irqf_q;
  logic busy_q, boot_q, busy_mark_q;
  logic [7:0] latch_q, eeprom_data_register_q, eeprom_address_register_q, rdata_q;
  logic rvalid_q;
  logic [15:0] fword_q;
  logic [CNT_W-1:0] cnt_q;
  logic [PTR_W-1:0] padr_q;
  pft_tgt_t tgt_q;
  pft_unlock_t ul_q;
  logic ctl_wr, start_ok, rd_ok, done;

  // Fetch word from two bytes, invalid encodings become a no-op
  function automatic logic [15:0] fetch_dec(input logic [15:0] w);
    fetch_dec = ((w & INV_MASK) == INV_VAL) ? NOP_WORD : w;
  endfunction

  // Write start needs gate set in the written value and the unlock armed
  assign ctl_wr = bus.reg_wr && bus.reg_sel == SEL_CTRL;
  assign start_ok = ctl_wr && bus.reg_wdata[CTL_WR] && !busy_q &&
    bus.reg_wdata[CTL_GATE] && ul_q == UL_ARMED;
  assign rd_ok = ctl_wr && bus.reg_wdata[CTL_RD] &&
    !bus.reg_wdata[CTL_SPACE] && !busy_q;
  assign done = busy_q && cnt_q == '0;

  // Unlock sequence: key1, key2, then the very next write must be the start
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ul_q <= UL_IDLE;
    end else if (bus.reg_wr) begin
      unique case (ul_q)
        UL_IDLE: ul_q <= (bus.reg_sel == SEL_UNLOCK &&
          bus.reg_wdata == UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: ul_q <= (bus.reg_sel == SEL_UNLOCK &&
          bus.reg_wdata == UNLOCK_KEY2) ? UL_ARMED : UL_IDLE;
        UL_ARMED: ul_q <= UL_IDLE;
      endcase
    end
  end

  // Control bits, start bits and the self-timed cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      space_q <= 1'b0;
      cfgsel_q <= 1'b0;
      erase_q <= 1'b0;
      gate_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
      padr_q <= '0;
      tgt_q <= TGT_EE;
    end else begin
      rd_q <= 1'b0;
      if (ctl_wr) begin
        space_q <= bus.reg_wdata[CTL_SPACE];
        cfgsel_q <= bus.reg_wdata[CTL_CFG];
        gate_q <= bus.reg_wdata[CTL_GATE];
        if (!done) begin
          erase_q <= bus.reg_wdata[CTL_ERASE];
        end
      end
      if (rd_ok) begin
        rd_q <= 1'b1;
      end
      if (start_ok) begin
        // Target is frozen here so later bit changes cannot alter it
        wr_q <= 1'b1;
        busy_q <= 1'b1;
        cnt_q <= CNT_W'(PROG_CYC - 1);
        padr_q <= bus.tbl_ptr;
        if (bus.reg_wdata[CTL_CFG]) begin
          tgt_q <= TGT_CFG;
        end else if (!bus.reg_wdata[CTL_SPACE]) begin
          tgt_q <= TGT_EE;
        end else if (bus.reg_wdata[CTL_ERASE]) begin
          tgt_q <= TGT_FER;
        end else begin
          tgt_q <= TGT_FWR;
        end
      end else if (done) begin
        wr_q <= 1'b0;
        busy_q <= 1'b0;
        if (tgt_q == TGT_FER) begin
          erase_q <= 1'b0;
        end
      end else if (busy_q) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // Completion flag: set wins over a same-cycle software clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irqf_q <= 1'b0;
    end else if (done) begin
      irqf_q <= 1'b1;
    end else if (bus.reg_wr && bus.reg_sel == SEL_IRQF) begin
      irqf_q <= bus.reg_wdata[IRQF_WC];
    end
  end

  // Busy marker has no reset, so it remembers a cycle cut by reset
  always_ff @(posedge i_clk) begin
    if (boot_q) begin
      busy_mark_q <= busy_q;
    end
  end

  // First edge after release raises the abort flag if a cycle was cut
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
      if (!boot_q) begin
        if (busy_mark_q) begin
          abort_q <= 1'b1;
        end
      end else if (done) begin
        abort_q <= 1'b0;
      end else if (ctl_wr) begin
        abort_q <= bus.reg_wdata[CTL_ABORT];
      end
    end
  end

  // Data and address registers are cleared by any reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eeprom_data_register_q <= BYTE_ZERO;
      eeprom_address_register_q <= BYTE_ZERO;
    end else begin
      if (bus.reg_wr && bus.reg_sel == SEL_EEPROM_ADDRESS_REGISTER) begin
        eeprom_address_register_q <= bus.reg_wdata;
      end
      if (rd_q) begin
        eeprom_data_register_q <= cfgsel_q ? cfgm_q[eeprom_address_register_q[3:0]] : ee_q[eeprom_address_register_q];
      end else if (bus.reg_wr && bus.reg_sel == SEL_EEPROM_DATA_REGISTER) begin
        eeprom_data_register_q <= bus.reg_wdata;
      end
    end
  end

  // Table latch: one byte per table read, from any byte address
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_q <= BYTE_ZERO;
    end else if (bus.tbl_rd && !busy_q) begin
      latch_q <= flash_q[bus.tbl_ptr];
    end else if (bus.reg_wr && bus.reg_sel == SEL_LATCH) begin
      latch_q <= bus.reg_wdata;
    end
  end

  // Holding registers take the latch; the array is untouched here
  always_ff @(posedge i_clk) begin
    if (bus.tbl_wr && !busy_q) begin
      hold_q[bus.tbl_ptr[2:0]] <= latch_q;
    end
  end

  // Array commits at the end of the timed cycle; only block-sized flash units
  // exist, so no bulk erase can be reached from the core
  always_ff @(posedge i_clk) begin
    if (done) begin
      unique case (tgt_q)
        TGT_FWR: begin
          for (int i = 0; i < WR_BLK; i++) begin
            flash_q[{padr_q[PTR_W-1:3], 3'(i)}] <= hold_q[i];
          end
        end
        TGT_FER: begin
          for (int i = 0; i < ER_BLK; i++) begin
            flash_q[{padr_q[PTR_W-1:6], 6'(i)}] <= ERASED_BYTE;
          end
        end
        TGT_EE: ee_q[eeprom_address_register_q] <= eeprom_data_register_q;
        TGT_CFG: cfgm_q[eeprom_address_register_q[3:0]] <= eeprom_data_register_q;
      endcase
    end
  end

  // Register read answers one cycle after the request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= BYTE_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.reg_rd;
      if (bus.reg_rd) begin
        unique case (bus.reg_sel)
          SEL_CTRL: rdata_q <= {space_q, cfgsel_q, 1'b0, erase_q, abort_q,
            gate_q, wr_q, rd_q};
          SEL_LATCH: rdata_q <= latch_q;
          SEL_EEPROM_DATA_REGISTER: rdata_q <= eeprom_data_register_q;
          SEL_EEPROM_ADDRESS_REGISTER: rdata_q <= eeprom_address_register_q;
          SEL_IRQF: rdata_q <= {7'h00, irqf_q};
          default: rdata_q <= BYTE_ZERO;
        endcase
      end
    end
  end

  // Fetch holds its last word while any array cycle runs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fword_q <= NOP_WORD;
    end else if (!busy_q) begin
      fword_q <= fetch_dec({flash_q[{bus.fetch_addr, 1'b1}],
        flash_q[{bus.fetch_addr, 1'b0}]});
    end
  end

  assign bus.reg_rdata = rdata_q;
  assign bus.reg_rvalid = rvalid_q;
  assign bus.fetch_word = fword_q;
  assign bus.fetch_stall = busy_q;
  assign o_irq_flag = irqf_q;
  assign o_abort_flag = abort_q;
endmodule // pft_mem_end

// [pft_core_end.sv]
// Purpose: Core end: turns Avalon-MM orders into register and table ops
// Assumes: One Avalon master, requests held until waitrequest is low
// Notes: Orders wait while the memory end stalls fetching
module pft_core_end
  import pft_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  pft_if.core bus,
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest
);
  pft_hst_t st_q;
  logic wait_q, wr_p_q, rd_p_q, tr_q, tw_q;
  logic [2:0] sel_q;
  logic [7:0] wdata_q;
  logic [31:0] rdata_q;
  logic [PTR_W-1:0] ptr_q;
  logic [WADDR_W-1:0] faddr_q;
  logic is_dev;

  assign is_dev = i_address < AV_PTR;

  // Order sequencer; a held request is served once, then acknowledged
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= H_IDLE;
      wait_q <= 1'b1;
      wr_p_q <= 1'b0;
      rd_p_q <= 1'b0;
      tr_q <= 1'b0;
      tw_q <= 1'b0;
      sel_q <= 3'h0;
      wdata_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      ptr_q <= '0;
      faddr_q <= '0;
    end else begin
      wr_p_q <= 1'b0;
      rd_p_q <= 1'b0;
      tr_q <= 1'b0;
      tw_q <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if ((i_read || i_write) && !bus.fetch_stall) begin
            sel_q <= i_address[4:2];
            wdata_q <= i_writedata[7:0];
            rdata_q <= 32'h0000_0000;
            if (i_read && is_dev) begin
              rd_p_q <= 1'b1;
              st_q <= H_WAIT;
            end else begin
              // Writes and local reads finish in one step
              wait_q <= 1'b0;
              st_q <= H_ACK;
              if (i_write) begin
                wr_p_q <= is_dev;
                if (i_address == AV_PTR) begin
                  ptr_q <= i_writedata[PTR_W-1:0];
                end
                if (i_address == AV_FETCH) begin
                  faddr_q <= i_writedata[WADDR_W-1:0];
                end
                if (i_address == AV_TBLOP) begin
                  tr_q <= i_writedata[0];
                  tw_q <= i_writedata[1] && !i_writedata[0];
                end
              end else if (i_address == AV_PTR) begin
                rdata_q <= {20'h00000, ptr_q};
              end else if (i_address == AV_STATUS) begin
                rdata_q <= {31'h0000_0000, bus.fetch_stall};
              end else if (i_address == AV_FETCH) begin
                rdata_q <= {16'h0000, bus.fetch_word};
              end
            end
          end
        end
        H_WAIT: begin
          if (bus.reg_rvalid) begin
            rdata_q <= {24'h000000, bus.reg_rdata};
            wait_q <= 1'b0;
            st_q <= H_ACK;
          end
        end
        H_ACK: begin
          wait_q <= 1'b1;
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.reg_wr = wr_p_q;
  assign bus.reg_rd = rd_p_q;
  assign bus.reg_sel = sel_q;
  assign bus.reg_wdata = wdata_q;
  assign bus.tbl_rd = tr_q;
  assign bus.tbl_wr = tw_q;
  assign bus.tbl_ptr = ptr_q;
  assign bus.fetch_addr = faddr_q;
  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
endmodule // pft_core_end

// [pft_chk.sv]
// Purpose: Concurrent checks on the link between the two ends
// Assumes: One clock domain, active low asynchronous reset
// Notes: Sees interface signals as plain inputs, no bind
module pft_chk
  import pft_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic [15:0] fetch_word,
  input wire logic fetch_stall
);
  logic [CNT_W-1:0] stall_cnt_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // Counts stalled edges; a repetition of 200 would be too slow to unroll
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stall_cnt_q <= '0;
    end else begin
      stall_cnt_q <= fetch_stall ? stall_cnt_q + 1'b1 : '0;
    end
  end

  // Timed cycle length and fetch blocking
  chk_stall_len: assert property (
    $fell(fetch_stall) |-> stall_cnt_q == PROG_CYC)
    else $error("timed cycle length wrong");
  chk_stall_max: assert property (
    fetch_stall |-> stall_cnt_q < PROG_CYC)
    else $error("timed cycle overran");
  chk_tbl_idle: assert property (
    fetch_stall |-> !tbl_rd && !tbl_wr)
    else $error("table op while stalled");
  chk_start_gated: assert property (
    $rose(fetch_stall) |-> $past(reg_wr && reg_sel == SEL_CTRL &&
      reg_wdata[CTL_GATE] && reg_wdata[CTL_WR]))
    else $error("cycle began without gated start");
  // Register answers
  chk_unlock_zero: assert property (
    reg_rd && reg_sel == SEL_UNLOCK |=> reg_rdata == BYTE_ZERO)
    else $error("unlock port read not zero");
  chk_rd_answer: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (
    reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  // Unwritten flash fetches as unknown, so only a word that truly
  // matches the invalid pattern may fire this check
  chk_fetch_valid: assert property (
    !((fetch_word & INV_MASK) === INV_VAL))
    else $error("invalid word fetched");

  cov_timed: cover property ($fell(fetch_stall));
  cov_unlock: cover property (reg_rd && reg_sel == SEL_UNLOCK);
  cov_tbl_rd: cover property (tbl_rd);
endmodule // pft_chk

// [program_flash_table_access_bench.sv]
// Purpose: Self-checking bench for both ends of the table access link
// Assumes: Avalon master holds each request until waitrequest is low
// Notes: Reads queue their expectation; a monitor compares at the ack
module program_flash_table_access_bench
  import pft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_UNL = 6'h04;
  localparam logic [5:0] A_LAT = 6'h08;
  localparam logic [5:0] A_EED = 6'h0c;
  localparam logic [5:0] A_EEA = 6'h10;
  localparam logic [5:0] A_IRQ = 6'h14;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [5:0] i_address = 6'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_irq_flag;
  logic o_abort_flag;
  logic [31:0] exp_q[$];
  logic [7:0] blk[16];
  logic [15:0] w;
  int n_errors = 0;
  int checked = 0;
  int seed = 32'h319d;
  int i;

  pft_if bus_if();
  pft_mem_end u_pft_mem_end (.i_clk(i_clk), .i_nrst(i_nrst), .bus(bus_if),
    .o_irq_flag(o_irq_flag), .o_abort_flag(o_abort_flag));
  pft_core_end u_pft_core_end (.i_clk(i_clk), .i_nrst(i_nrst),
    .bus(bus_if), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest));
  pft_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_sel(bus_if.reg_sel),
    .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .reg_rvalid(bus_if.reg_rvalid), .tbl_rd(bus_if.tbl_rd),
    .tbl_wr(bus_if.tbl_wr), .fetch_word(bus_if.fetch_word),
    .fetch_stall(bus_if.fetch_stall));

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One Avalon transfer; the slave decides how long it waits
  task automatic av(input logic [5:0] a, input logic wr,
    input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge i_clk);
    if (!wr) exp_q.push_back(e);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 600);
    i_write <= 1'b0;
    i_read <= 1'b0;
    if (n >= 600) check(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    av(a, 1'b1, d, 32'h0);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    av(a, 1'b0, 32'h0, e);
  endtask

  // Unlock pair, start, then wait for and clear the completion flag
  task automatic start(input logic [7:0] ctl);
    int n;
    wr(A_UNL, UNLOCK_KEY1);
    wr(A_UNL, UNLOCK_KEY2);
    wr(A_CTRL, ctl);
    n = 0;
    while (o_irq_flag !== 1'b1 && n < 600) begin
      @(posedge i_clk);
      n++;
    end
    repeat (20) @(negedge i_clk);
    check({31'h0, o_irq_flag}, 32'h1);
    wr(A_IRQ, 32'h0);
    repeat (2) @(negedge i_clk);
    check({31'h0, o_irq_flag}, 32'h0);
  endtask

  task automatic tread(input logic [11:0] a, input logic [31:0] e);
    wr(AV_PTR, a);
    wr(AV_TBLOP, 32'h1);
    rd(A_LAT, e);
  endtask

  task automatic prog(input logic [11:0] a, input int k);
    for (int j = 0; j < WR_BLK; j++) begin
      wr(A_LAT, blk[k+j]);
      wr(AV_PTR, a + 12'(j));
      wr(AV_TBLOP, 32'h2);
    end
    start(8'h86);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(A_CTRL, 32'h0);
    wr(A_LAT, 32'h5a);
    rd(A_LAT, 32'h5a);
    rd(A_UNL, 32'h0);
    rd(6'h18, 32'h0);
    for (i = 0; i < 16; i++) blk[i] = 8'($random(seed));
    blk[1] = 8'h01;
    prog(12'h140, 0);
    prog(12'h180, 8);
    rd(A_CTRL, 32'h84);
    for (i = 0; i < 8; i++) tread(12'h140 + 12'(i), blk[i]);
    for (i = 0; i < 4; i++) begin
      w = {blk[2*i+1], blk[2*i]};
      wr(AV_FETCH, 32'ha0 + i);
      rd(AV_FETCH, ((w & INV_MASK) == INV_VAL) ? NOP_WORD : w);
    end
    start(8'h96);
    tread(12'h140, ERASED_BYTE);
    tread(12'h17f, ERASED_BYTE);
    tread(12'h181, blk[9]);
    rd(AV_PTR, 32'h181);
    rd(AV_STATUS, 32'h0);
    // A table write alone must leave the array as it was
    wr(A_LAT, {24'h0, ~blk[9]});
    wr(AV_TBLOP, 32'h2);
    tread(12'h181, blk[9]);
    rd(A_CTRL, 32'h84);
    // Starts that must be refused
    wr(A_UNL, UNLOCK_KEY1);
    wr(A_UNL, UNLOCK_KEY2);
    wr(A_CTRL, 32'h82);
    rd(A_CTRL, 32'h80);
    wr(A_CTRL, 32'h86);
    wr(A_CTRL, 32'h81);
    rd(A_CTRL, 32'h80);
    repeat (250) @(negedge i_clk);
    check({31'h0, o_irq_flag}, 32'h0);
    // Data EEPROM then configuration space at the same address
    wr(A_EEA, 32'h03);
    wr(A_EED, 32'hc3);
    start(8'h06);
    wr(A_EED, 32'h3c);
    start(8'hc6);
    wr(A_CTRL, 32'h01);
    rd(A_EED, 32'hc3);
    wr(A_CTRL, 32'h41);
    rd(A_EED, 32'h3c);
    // Reset cuts a running cycle
    wr(A_UNL, UNLOCK_KEY1);
    wr(A_UNL, UNLOCK_KEY2);
    wr(A_CTRL, 32'h06);
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(negedge i_clk);
    check({31'h0, o_abort_flag}, 32'h1);
    rd(A_EED, 32'h0);
    rd(A_EEA, 32'h0);
    rd(A_CTRL, 32'h08);
    end_sim();
  end

  // Monitor: each acknowledged read takes the oldest expectation
  always @(posedge i_clk) begin
    if (i_read && o_waitrequest === 1'b0 && exp_q.size() > 0)
      check(o_readdata, exp_q.pop_front());
  end

  // Watchdog, about five times the expected run
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule // program_flash_table_access_bench
